// file: hw/cmmt_regs.sv
// module: mask, mailbox port, message timer and time-stamp registers
`default_nettype none
module cmmt_regs
    import cmmt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // reception filter compare and transmission check
    input wire logic [28:0] rx_id_i,
    input wire logic rx_rtr_i,
    input wire logic rx_ext_i,
    input wire logic [28:0] tag_id_i,
    input wire logic tag_rtr_i,
    input wire logic tag_ext_i,
    input wire logic rx_check_i,
    output logic rx_hit_o,
    input wire logic tx_check_i,
    output logic tx_hit_o,
    // time-stamp capture at frame end
    input wire logic stamp_capture_i,
    // timer value
    output logic [15:0] msg_timer_value_o
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] accept_mask_byte3_q;
    logic [7:0] accept_mask_byte4_q;
    logic [7:0] timer_divider_q;
    logic [15:0] msg_timer_value_q;
    logic [15:0] stamp_value_q;
    logic [7:0] page_q;
    logic [7:0] mailbox_byte_q [CMMT_OBJECTS*CMMT_MSG_BYTES];
    logic tick;
    logic req;
    logic [7:0] idx;
    logic hit_map;
    logic [7:0] wbyte;
    logic [4:0] mb_addr;
    logic [2:0] ptr;
    logic [1:0] obj;
    logic ack_q;
    logic err_q;

    function automatic logic masked_eq(input logic a, input logic b,
                                       input logic m);
        masked_eq = !m || (a == b);
    endfunction

    assign req = cyc_i && stb_i && !ack_q && !err_q;
    assign idx = adr_i[9:2];
    assign wbyte = dat_i[7:0];
    assign ptr = page_q[CMMT_PAGE_PTR_LSB +: 3];
    assign obj = page_q[CMMT_PAGE_OBJ_LSB +: 2];
    assign mb_addr = {obj, ptr};

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        if (idx == CMMT_IDX_PRESCALE) begin
            hit_map = 1'b1;
        end else if (idx == CMMT_IDX_MAILBOX) begin
            hit_map = 1'b1;
        end else if (idx == CMMT_IDX_TIMER_LO
                     || idx == CMMT_IDX_TIMER_HI) begin
            hit_map = 1'b1;
        end else if (idx == CMMT_IDX_STAMP_LO
                     || idx == CMMT_IDX_STAMP_HI) begin
            hit_map = 1'b1;
        end else if (idx == CMMT_IDX_MASK3 || idx == CMMT_IDX_MASK4) begin
            hit_map = 1'b1;
        end else if (idx == CMMT_IDX_PAGE) begin
            hit_map = 1'b1;
        end else begin
            hit_map = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus answer: one cycle after request, ack or err
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && hit_map;
            err_q <= req && !hit_map;
        end
    end
    assign ack_o = ack_q;
    assign err_o = err_q;

    // write strobe taken in the ack cycle, so one write per request
    logic wr;
    logic rd;
    logic [7:0] sidx;
    logic swe;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sidx <= 8'h00;
            swe <= 1'b0;
        end else if (req) begin
            sidx <= idx;
            swe <= we_i && sel_i[0];
        end
    end
    assign wr = ack_q && swe;
    assign rd = ack_q && !swe;

    // ------------------------------------------------------------
    // mask registers, no reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (wr && sidx == CMMT_IDX_MASK3) begin
            accept_mask_byte3_q <= dat_i[7:0];
        end
        if (wr && sidx == CMMT_IDX_MASK4) begin
            accept_mask_byte4_q <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // prescaler and page
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_divider_q <= CMMT_PRESCALE_RST;
        end else if (wr && sidx == CMMT_IDX_PRESCALE) begin
            timer_divider_q <= wbyte;
        end
    end

    // mailbox pointer advances after each port access while the auto-increment bit is set, wraps in 8 bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_q <= CMMT_PAGE_RST;
        end else if (wr && sidx == CMMT_IDX_PAGE) begin
            page_q <= wbyte;
        end else if ((wr || rd) && sidx == CMMT_IDX_MAILBOX
                     && page_q[CMMT_PAGE_AINC_BIT]) begin
            page_q[CMMT_PAGE_PTR_LSB +: 3] <= ptr + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // mailbox storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (wr && sidx == CMMT_IDX_MAILBOX) begin
            mailbox_byte_q[mb_addr] <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // message timer and time stamp
    // ------------------------------------------------------------
    cmmt_tick u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divider_i(timer_divider_q),
        .tick_o(tick)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_timer_value_q <= CMMT_TIMER_RST;
        end else if (wr && sidx == CMMT_IDX_TIMER_LO) begin
            msg_timer_value_q[7:0] <= wbyte;
        end else if (wr && sidx == CMMT_IDX_TIMER_HI) begin
            msg_timer_value_q[15:8] <= wbyte;
        end else if (tick) begin
            msg_timer_value_q <= msg_timer_value_q + 16'h0001;
        end
    end
    assign msg_timer_value_o = msg_timer_value_q;

    // stamp has no reset and no bus write path
    always_ff @(posedge clk_i) begin
        if (stamp_capture_i) begin
            stamp_value_q <= msg_timer_value_q;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req) begin
            dat_o <= 32'h0000_0000;
            if (idx == CMMT_IDX_PRESCALE) begin
                dat_o[7:0] <= timer_divider_q;
            end else if (idx == CMMT_IDX_MAILBOX) begin
                dat_o[7:0] <= mailbox_byte_q[mb_addr];
            end else if (idx == CMMT_IDX_TIMER_LO) begin
                dat_o[7:0] <= msg_timer_value_q[7:0];
            end else if (idx == CMMT_IDX_TIMER_HI) begin
                dat_o[7:0] <= msg_timer_value_q[15:8];
            end else if (idx == CMMT_IDX_STAMP_LO) begin
                dat_o[7:0] <= stamp_value_q[7:0];
            end else if (idx == CMMT_IDX_STAMP_HI) begin
                dat_o[7:0] <= stamp_value_q[15:8];
            end else if (idx == CMMT_IDX_MASK3) begin
                dat_o[7:0] <= accept_mask_byte3_q;
            end else if (idx == CMMT_IDX_MASK4) begin
                // reserved bit returns whatever is stored
                dat_o[7:0] <= accept_mask_byte4_q;
            end else if (idx == CMMT_IDX_PAGE) begin
                dat_o[7:0] <= page_q;
            end
        end
    end

    // ------------------------------------------------------------
    // acceptance compare, low id bits 12..0 plus flags
    // ------------------------------------------------------------
    logic [12:0] id_mask;
    logic id_ok;
    always_comb begin
        id_mask = {accept_mask_byte3_q, accept_mask_byte4_q[7:3]};
        id_ok = 1'b1;
        for (int i = 0; i < 13; i++) begin
            id_ok = id_ok && masked_eq(rx_id_i[i], tag_id_i[i],
                                       id_mask[i]);
        end
    end
    assign rx_hit_o = rx_check_i && id_ok
        && masked_eq(rx_rtr_i, tag_rtr_i,
                     accept_mask_byte4_q[CMMT_RTR_MASK_BIT])
        && masked_eq(rx_ext_i, tag_ext_i,
                     accept_mask_byte4_q[CMMT_EXT_MASK_BIT]);
    // transmission ignores the mask entirely
    assign tx_hit_o = tx_check_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_req;
        req && hit_map;
    endsequence
    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i) s_req |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack timing");
    property p_tx;
        @(posedge clk_i) disable iff (rst_i) tx_hit_o == tx_check_i;
    endproperty
    a_tx: assert property (p_tx) else $error("tx masked");
    property p_rx_nocheck;
        @(posedge clk_i) disable iff (rst_i) !rx_check_i |-> !rx_hit_o;
    endproperty
    a_rx_nocheck: assert property (p_rx_nocheck) else $error("rx hit");
    property p_rtr;
        @(posedge clk_i) disable iff (rst_i)
            rx_check_i && accept_mask_byte4_q[CMMT_RTR_MASK_BIT]
            && rx_rtr_i != tag_rtr_i |-> !rx_hit_o;
    endproperty
    a_rtr: assert property (p_rtr) else $error("rtr compare");
    property p_ext;
        @(posedge clk_i) disable iff (rst_i)
            rx_check_i && accept_mask_byte4_q[CMMT_EXT_MASK_BIT]
            && rx_ext_i != tag_ext_i |-> !rx_hit_o;
    endproperty
    a_ext: assert property (p_ext) else $error("ext compare");
    property p_tmr_rst;
        @(posedge clk_i) rst_i |=> msg_timer_value_o == CMMT_TIMER_RST;
    endproperty
    a_tmr_rst: assert property (p_tmr_rst) else $error("timer reset");
    property p_stamp;
        @(posedge clk_i) disable iff (rst_i)
            stamp_capture_i |=> stamp_value_q == $past(msg_timer_value_q);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp value");
    property p_div_rst;
        @(posedge clk_i) rst_i |=> timer_divider_q == CMMT_PRESCALE_RST;
    endproperty
    a_div_rst: assert property (p_div_rst) else $error("prescaler");
    property p_ainc;
        @(posedge clk_i) disable iff (rst_i)
            ack_q && sidx == CMMT_IDX_MAILBOX && page_q[CMMT_PAGE_AINC_BIT]
            |=> ptr == $past(ptr) + 3'h1;
    endproperty
    a_ainc: assert property (p_ainc) else $error("auto increment");
    sequence s_tmr_lo_wr;
        wr && sidx == CMMT_IDX_TIMER_LO;
    endsequence
    sequence s_tmr_hi_wr;
        wr && sidx == CMMT_IDX_TIMER_HI;
    endsequence
    property p_tmr_lo;
        @(posedge clk_i) disable iff (rst_i)
            s_tmr_lo_wr |=> msg_timer_value_q[7:0] == $past(wbyte);
    endproperty
    a_tmr_lo: assert property (p_tmr_lo) else $error("timer low");
    property p_tmr_hi;
        @(posedge clk_i) disable iff (rst_i)
            s_tmr_hi_wr |=> msg_timer_value_q[15:8] == $past(wbyte);
    endproperty
    a_tmr_hi: assert property (p_tmr_hi) else $error("timer high");
    property p_tmr_hold;
        @(posedge clk_i) disable iff (rst_i)
            !tick && !(wr && (sidx == CMMT_IDX_TIMER_LO
                              || sidx == CMMT_IDX_TIMER_HI))
            |=> $stable(msg_timer_value_q);
    endproperty
    a_tmr_hold: assert property (p_tmr_hold) else $error("timer step");
    property p_div_wr;
        @(posedge clk_i) disable iff (rst_i)
            wr && sidx == CMMT_IDX_PRESCALE
            |=> timer_divider_q == $past(wbyte);
    endproperty
    a_div_wr: assert property (p_div_wr) else $error("divider write");
    property p_id_cmp;
        @(posedge clk_i) disable iff (rst_i)
            rx_check_i
            && (((rx_id_i[12:0] ^ tag_id_i[12:0]) & id_mask) != 13'h0000)
            |-> !rx_hit_o;
    endproperty
    a_id_cmp: assert property (p_id_cmp) else $error("id compare");
    property p_page_rst;
        @(posedge clk_i) rst_i |=> page_q == CMMT_PAGE_RST;
    endproperty
    a_page_rst: assert property (p_page_rst) else $error("page reset");
endmodule
`default_nettype wire

// file: hw/cmmt_pkg.sv
// package: register map, field positions and reset values of the block
`default_nettype none
package cmmt_pkg;
    // register offsets (byte address = 4 * index, printed offsets are odd)
    localparam logic [7:0] CMMT_IDX_PRESCALE = 8'hA1;
    localparam logic [7:0] CMMT_IDX_MAILBOX = 8'hA3;
    localparam logic [7:0] CMMT_IDX_TIMER_LO = 8'hAC;
    localparam logic [7:0] CMMT_IDX_TIMER_HI = 8'hAD;
    localparam logic [7:0] CMMT_IDX_STAMP_LO = 8'hAE;
    localparam logic [7:0] CMMT_IDX_STAMP_HI = 8'hAF;
    localparam logic [7:0] CMMT_IDX_MASK3 = 8'hC6;
    localparam logic [7:0] CMMT_IDX_MASK4 = 8'hC7;
    // own control registers: mailbox page and auto-increment
    localparam logic [7:0] CMMT_IDX_PAGE = 8'hB1;
    // field positions in mask byte 4
    localparam int CMMT_RTR_MASK_BIT = 2;
    localparam int CMMT_RSVD_BIT = 1;
    localparam int CMMT_EXT_MASK_BIT = 0;
    // page register fields
    localparam int CMMT_PAGE_AINC_BIT = 7;
    localparam int CMMT_PAGE_OBJ_LSB = 4;
    localparam int CMMT_PAGE_PTR_LSB = 0;
    // reset values
    localparam logic [7:0] CMMT_PRESCALE_RST = 8'h00;
    localparam logic [15:0] CMMT_TIMER_RST = 16'h0000;
    localparam logic [7:0] CMMT_PAGE_RST = 8'h00;
    // mailbox geometry
    localparam int CMMT_OBJECTS = 4;
    localparam int CMMT_MSG_BYTES = 8;
    // fixed pre-divide of the system clock ahead of the prescaler
    localparam logic [2:0] CMMT_PREDIV_LAST = 3'h5;
endpackage
`default_nettype wire

// file: hw/cmmt_tick.sv
// module: programmable divider giving the message timer tick
`default_nettype none
module cmmt_tick
    import cmmt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic [7:0] divider_i,
    // tick out
    output logic tick_o
);
    logic [2:0] pre_q;
    logic [7:0] cnt_q;
    logic pre_tick;

    assign pre_tick = (pre_q == CMMT_PREDIV_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i || pre_tick) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // divide by divider+1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (pre_tick) begin
                if (cnt_q >= divider_i) begin
                    cnt_q <= 8'h00;
                    tick_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/cmmt_regs_tb_top.sv
// testbench: register access, filter compare, timer and stamp of cmmt_regs
`default_nettype none
module cmmt_regs_tb_top;
    import cmmt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cap = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack_o, err_o, rx_hit_o, tx_hit_o;
    logic [28:0] rx_id = 29'h0, tag_id = 29'h0ABC;
    logic rx_rtr = 1'b1, rx_ext = 1'b1, rx_chk = 1'b1, tx_chk = 1'b0;
    logic tag_rtr = 1'b1, tag_ext = 1'b1;
    logic [15:0] msg_timer_value_o;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic e;
    cmmt_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .rx_id_i(rx_id), .rx_rtr_i(rx_rtr),
        .rx_ext_i(rx_ext), .tag_id_i(tag_id), .tag_rtr_i(tag_rtr),
        .tag_ext_i(tag_ext), .rx_check_i(rx_chk), .rx_hit_o(rx_hit_o),
        .tx_check_i(tx_chk), .tx_hit_o(tx_hit_o), .stamp_capture_i(cap),
        .msg_timer_value_o(msg_timer_value_o));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle; ack or err sampled at the rising edge
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o[7:0];
        e = err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx,
                         input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        chk(what, {7'h00, e, rd}, {8'h00, exp});
    endtask
    task automatic hit(input logic [28:0] id, input logic rtr,
                       input logic ext, input logic exp);
        @(posedge clk_i);
        rx_id <= id;
        rx_rtr <= rtr;
        rx_ext <= ext;
        @(negedge clk_i);
        chk("rx_hit", {15'h0, rx_hit_o}, {15'h0, exp});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdchk("prescale rst", CMMT_IDX_PRESCALE, CMMT_PRESCALE_RST);
        wr(CMMT_IDX_PRESCALE, 8'hFF);
        rdchk("prescale", CMMT_IDX_PRESCALE, 8'hFF);
        wr(CMMT_IDX_MASK3, 8'hA5);
        rdchk("mask3", CMMT_IDX_MASK3, 8'hA5);
        wr(CMMT_IDX_MASK4, 8'h5D);
        bus(1'b1, CMMT_IDX_MASK4, 8'h00, 4'h2);
        rdchk("mask4 sel", CMMT_IDX_MASK4, 8'h5D);
        bus(1'b0, 8'h03, 8'h00, 4'h1);
        chk("unmapped err", {15'h0, e}, 16'h0001);
    endtask
    task automatic t_filter();
        wr(CMMT_IDX_MASK3, 8'hFF);
        wr(CMMT_IDX_MASK4, 8'hFD);
        hit(29'h0ABC, 1'b1, 1'b1, 1'b1);
        hit(29'h0ABD, 1'b1, 1'b1, 1'b0);
        hit(29'h2ABC, 1'b1, 1'b1, 1'b1);
        hit(29'h0ABC, 1'b0, 1'b1, 1'b0);
        hit(29'h0ABC, 1'b1, 1'b0, 1'b0);
        @(posedge clk_i);
        tag_rtr <= 1'b0;
        tag_ext <= 1'b0;
        hit(29'h0ABC, 1'b0, 1'b0, 1'b1);
        chk("tx idle", {15'h0, tx_hit_o}, 16'h0000);
        @(posedge clk_i);
        tag_rtr <= 1'b1;
        tag_ext <= 1'b1;
        wr(CMMT_IDX_MASK4, 8'hF0);
        hit(29'h0ABD, 1'b0, 1'b0, 1'b1);
        wr(CMMT_IDX_MASK4, 8'hE8);
        hit(29'h0ABC, 1'b0, 1'b0, 1'b1);
        tx_chk <= 1'b1;
        hit(29'h0123, 1'b0, 1'b0, 1'b0);
        chk("tx_hit", {15'h0, tx_hit_o}, 16'h0001);
    endtask
    task automatic t_timer();
        logic [15:0] v0;
        for (int p = 0; p < 4; p += 3) begin
            wr(CMMT_IDX_PRESCALE, p[7:0]);
            wr(CMMT_IDX_TIMER_HI, 8'h00);
            @(negedge clk_i);
            v0 = msg_timer_value_o;
            repeat (60 * (p + 1)) @(negedge clk_i);
            chk("tick rate", msg_timer_value_o - v0, 16'h000A);
        end
        wr(CMMT_IDX_PRESCALE, 8'hFF);
        wr(CMMT_IDX_TIMER_HI, 8'h12);
        wr(CMMT_IDX_TIMER_LO, 8'h34);
        @(posedge clk_i);
        cap <= 1'b1;
        @(posedge clk_i);
        cap <= 1'b0;
        rdchk("timer hi", CMMT_IDX_TIMER_HI, 8'h12);
        wr(CMMT_IDX_STAMP_LO, 8'h99);
        rdchk("stamp lo", CMMT_IDX_STAMP_LO, 8'h34);
        rdchk("stamp hi", CMMT_IDX_STAMP_HI, 8'h12);
    endtask
    task automatic t_mailbox();
        logic [7:0] bytes[3] = '{8'hA1, 8'hB2, 8'hC3};
        wr(CMMT_IDX_PAGE, 8'h96);
        foreach (bytes[i]) wr(CMMT_IDX_MAILBOX, bytes[i]);
        wr(CMMT_IDX_PAGE, 8'hA6);
        wr(CMMT_IDX_MAILBOX, 8'h5E);
        wr(CMMT_IDX_PAGE, 8'h96);
        foreach (bytes[i]) rdchk("mailbox", CMMT_IDX_MAILBOX, bytes[i]);
        rdchk("page wrap", CMMT_IDX_PAGE, 8'h91);
    endtask
    task automatic t_reset();
        wr(CMMT_IDX_PAGE, 8'h85);
        wr(CMMT_IDX_TIMER_HI, 8'h5A);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("timer rst2", msg_timer_value_o, CMMT_TIMER_RST);
        @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("prescale rst2", CMMT_IDX_PRESCALE, CMMT_PRESCALE_RST);
        rdchk("page rst2", CMMT_IDX_PAGE, CMMT_PAGE_RST);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        chk("timer rst", msg_timer_value_o, CMMT_TIMER_RST);
        rst_i <= 1'b0;
        t_regs();
        t_filter();
        t_timer();
        t_mailbox();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
